// [verilog/cfmd_top.sv]
// Purpose: clock failure supervision, backup switchover and bus clock distribution
// Assumes: all inputs synchronous to mclk; clock levels are sampled copies
// Notes: no software registers; control arrives as plain ports
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - watch the core system clock outside sleep for a stop in toggling
// - on failure switch the system clock source to the backup rc oscillator
// - on failure raise a non-maskable interrupt to the processor
// - backup rc oscillator drives system clock throughout the failure event
// - in sleep both clock and monitor halt; no failure detected then
// - peripheral bus clock one always runs; disable requests ignored
// - in certain modes drive bus clock one divided by two on oscillator pin
// - flash transfers use the primary source; programming uses fast rc
// - marked peripherals use bus clock for register access only
module cfmd_top
  import cfmd_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic core_system_clock_level,
  input wire logic sleep_mode,
  input wire logic osc_reconfigure,
  input wire logic pb1_disable_req,
  input wire logic pb1_tick,
  input wire logic osc_out_mode,
  input wire logic flash_program,
  input wire logic sfr_access,
  output logic [1:0] sys_clk_source,
  output logic nmi_pulse,
  output logic clock_fail_flag,
  output logic pb1_enable,
  output logic oscillator_output_pin,
  output logic [1:0] flash_clk_source,
  output logic periph_reg_clk_en
);
  import cfmd_pkg::*;

  cfmd_state_t state;
  logic stopped;
  logic fail_event;
  logic pb1_half;

  cfmd_edge_watch u_watch (
    .mclk(mclk),
    .srst(srst),
    .hold(sleep_mode),
    .clk_level(core_system_clock_level),
    .stopped(stopped)
  );

  // stopped lingers two cycles after a restart, so an early reconfigure refires
  always_comb
  begin
    fail_event = 1'b0;
    if (state == CFMD_RUN)
      fail_event = stopped && !sleep_mode;
  end

  // latched failure; only leaves on software reconfiguration or srst
  always_ff @(posedge mclk)
  begin
    if (srst)
      state <= CFMD_RUN;
    else
    begin
      case (state)
        CFMD_RUN:
          if (fail_event)
            state <= CFMD_FAILED;
        CFMD_FAILED:
          if (osc_reconfigure)
            state <= CFMD_RUN;
        default:
          state <= CFMD_RUN;
      endcase
    end
  end

  // one pulse per entry into failure, not per cycle stopped
  always_ff @(posedge mclk)
  begin
    if (srst)
      nmi_pulse <= 1'b0;
    else
    begin
      case (state)
        CFMD_RUN:
          nmi_pulse <= fail_event;
        CFMD_FAILED:
          nmi_pulse <= 1'b0;
        default:
          nmi_pulse <= 1'b0;
      endcase
    end
  end

  // backup drives the system clock from the failing edge until reconfigure
  always_ff @(posedge mclk)
  begin
    if (srst)
      sys_clk_source <= SRC_PRIMARY;
    else
    begin
      case (state)
        CFMD_RUN:
          if (fail_event)
            sys_clk_source <= SRC_BACKUP;
          else
            sys_clk_source <= SRC_PRIMARY;
        CFMD_FAILED:
          if (osc_reconfigure)
            sys_clk_source <= SRC_PRIMARY;
          else
            sys_clk_source <= SRC_BACKUP;
        default:
          sys_clk_source <= SRC_PRIMARY;
      endcase
    end
  end

  // reconfigure wins over a held failure
  always_ff @(posedge mclk)
  begin
    if (srst)
      clock_fail_flag <= 1'b0;
    else
    begin
      case (state)
        CFMD_RUN:
          clock_fail_flag <= fail_event;
        CFMD_FAILED:
          clock_fail_flag <= !osc_reconfigure;
        default:
          clock_fail_flag <= 1'b0;
      endcase
    end
  end

  // disable request deliberately unused: system modules depend on this clock
  always_ff @(posedge mclk)
  begin
    if (srst)
      pb1_enable <= 1'b1;
    else
      pb1_enable <= 1'b1 | pb1_disable_req;
  end

  // toggle on each bus clock tick gives half rate
  // phase restarts while the pin is off, so the first driven half period is full
  always_ff @(posedge mclk)
  begin
    if (srst)
      pb1_half <= 1'b0;
    else if (!osc_out_mode)
      pb1_half <= 1'b0;
    else if (pb1_tick)
      pb1_half <= ~pb1_half;
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
      oscillator_output_pin <= 1'b0;
    else
      oscillator_output_pin <= osc_out_mode & pb1_half;
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
      flash_clk_source <= SRC_PRIMARY;
    else if (flash_program)
      flash_clk_source <= SRC_FAST_RC;
    else
      flash_clk_source <= SRC_PRIMARY;
  end

  // functional logic of these peripherals runs elsewhere
  always_ff @(posedge mclk)
  begin
    if (srst)
      periph_reg_clk_en <= 1'b0;
    else
      periph_reg_clk_en <= sfr_access;
  end
endmodule
`default_nettype wire

// [verilog/cfmd_pkg.sv]
// Purpose: shared constants for the clock fail monitor and distribution block
// Assumes: one clock mclk at 25 MHz; clock presence inputs are sampled as synchronous levels
// Notes: timing counts derive from times and the clock rate
package cfmd_pkg;
  localparam int unsigned CLK_HZ = 25000000;
  // a stuck system clock is declared after this long without an edge
  localparam int unsigned FAIL_TIMEOUT_NS = 400;
  localparam int unsigned FAIL_TIMEOUT_CYC = (FAIL_TIMEOUT_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int unsigned CNT_W = 8;
  localparam logic [CNT_W-1:0] FAIL_TIMEOUT = FAIL_TIMEOUT_CYC[CNT_W-1:0];
  localparam int unsigned BACKUP_RC_MHZ = 8;
  localparam int unsigned PB1_DIV = 2;
  // system and flash clock source selection codes
  localparam logic [1:0] SRC_PRIMARY = 2'h0;
  localparam logic [1:0] SRC_BACKUP = 2'h1;
  localparam logic [1:0] SRC_FAST_RC = 2'h2;
  typedef enum logic [1:0] {CFMD_RUN, CFMD_FAILED} cfmd_state_t;
endpackage

// [verilog/cfmd_edge_watch.sv]
// Purpose: detects a stopped clock from a sampled clock level
// Assumes: clock level arrives synchronous to mclk
// Notes: counts cycles since the last toggle; held at zero while hold is high
`timescale 1ns/10ps
`default_nettype none
module cfmd_edge_watch
  import cfmd_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic hold,
  input wire logic clk_level,
  output logic stopped
);
  logic last_level;
  logic [CNT_W-1:0] idle_cnt;

  always_ff @(posedge mclk)
  begin
    if (srst)
      last_level <= 1'b0;
    else
      last_level <= clk_level;
  end

  // counter is held at zero in sleep so no detection happens then
  always_ff @(posedge mclk)
  begin
    if (srst || hold || (clk_level != last_level))
      idle_cnt <= '0;
    else if (idle_cnt != FAIL_TIMEOUT)
      idle_cnt <= idle_cnt + 8'h01;
  end

  always_ff @(posedge mclk)
  begin
    if (srst || hold)
      stopped <= 1'b0;
    else
      stopped <= (idle_cnt == FAIL_TIMEOUT);
  end
endmodule
`default_nettype wire

// [test/cfmd_chk_checker.sv]
// Purpose: port checks for cfmd_top
// Assumes: one clock domain
// Notes: bound with every port named
`timescale 1ns/10ps
`default_nettype none
module cfmd_chk
  import cfmd_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic sleep_mode,
  input wire logic osc_reconfigure,
  input wire logic osc_out_mode,
  input wire logic flash_program,
  input wire logic sfr_access,
  input wire logic [1:0] sys_clk_source,
  input wire logic nmi_pulse,
  input wire logic clock_fail_flag,
  input wire logic pb1_enable,
  input wire logic oscillator_output_pin,
  input wire logic [1:0] flash_clk_source,
  input wire logic periph_reg_clk_en
);
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  sequence s_alarm; nmi_pulse && sys_clk_source == SRC_BACKUP ##1 !nmi_pulse; endsequence
  property p_rise; $rose(clock_fail_flag) |-> s_alarm; endproperty
  a_rise: assert property (p_rise) else $error("no alarm on failure");
  property p_once; nmi_pulse |-> $rose(clock_fail_flag); endproperty
  a_once: assert property (p_once) else $error("stray nmi");
  property p_hold; clock_fail_flag && !osc_reconfigure |=> clock_fail_flag && sys_clk_source == SRC_BACKUP; endproperty
  a_hold: assert property (p_hold) else $error("backup dropped");
  property p_rcfg; osc_reconfigure |=> !clock_fail_flag && sys_clk_source == SRC_PRIMARY; endproperty
  a_rcfg: assert property (p_rcfg) else $error("reconfigure ignored");
  // two cycles of slack for a failure already in flight
  property p_slp; sleep_mode [*3] |-> !nmi_pulse; endproperty
  a_slp: assert property (p_slp) else $error("nmi in sleep");
  property p_pb1; pb1_enable; endproperty
  a_pb1: assert property (p_pb1) else $error("bus clock off");
  property p_pin; !osc_out_mode |=> !oscillator_output_pin; endproperty
  a_pin: assert property (p_pin) else $error("pin driven");
  property p_fl; flash_program |=> flash_clk_source == SRC_FAST_RC; endproperty
  a_fl: assert property (p_fl) else $error("flash clock");
  property p_reg_on; sfr_access |=> periph_reg_clk_en; endproperty
  a_reg_on: assert property (p_reg_on) else $error("register clock missing");
  property p_reg_off; !sfr_access |=> !periph_reg_clk_en; endproperty
  a_reg_off: assert property (p_reg_off) else $error("register clock stray");
endmodule
bind cfmd_top cfmd_chk i_chk (
  .mclk(mclk),
  .srst(srst),
  .sleep_mode(sleep_mode),
  .osc_reconfigure(osc_reconfigure),
  .osc_out_mode(osc_out_mode),
  .flash_program(flash_program),
  .sfr_access(sfr_access),
  .sys_clk_source(sys_clk_source),
  .nmi_pulse(nmi_pulse),
  .clock_fail_flag(clock_fail_flag),
  .pb1_enable(pb1_enable),
  .oscillator_output_pin(oscillator_output_pin),
  .flash_clk_source(flash_clk_source),
  .periph_reg_clk_en(periph_reg_clk_en)
);
`default_nettype wire

// [test/cfmd_osc_model.sv]
// Purpose: main oscillator stand-in
// Assumes: run set off the falling edge
// Notes: a dead clock holds its level
`timescale 1ns/10ps
`default_nettype none
module cfmd_osc_model
(
  input wire logic mclk,
  input wire logic run,
  output logic level = 1'b0
);
  always @(posedge mclk)
    level <= run ? ~level : level;
endmodule
`default_nettype wire

// [test/cfmd_top_tb.sv]
// Purpose: bench for cfmd_top
// Assumes: inputs change on falling edge
// Notes: no random stimulus
`timescale 1ns/10ps
`default_nettype none
module cfmd_top_tb;
  import cfmd_pkg::*;
  logic mclk = 0, srst = 1, run = 1, slp = 0, rc = 0, dis = 0, tk = 0, om = 0, fp = 0, special_function_register = 0;
  logic lv, nmi, flag, pb1, pin, rce;
  logic [1:0] src, fsrc;
  int failures = 0;
  int checks = 0;
  always #20 mclk = ~mclk;
  cfmd_osc_model i_osc (.mclk(mclk), .run(run), .level(lv));
  cfmd_top i_dut (.mclk(mclk), .srst(srst), .core_system_clock_level(lv), .sleep_mode(slp),
    .osc_reconfigure(rc), .pb1_disable_req(dis), .pb1_tick(tk), .osc_out_mode(om), .flash_program(fp),
    .sfr_access(special_function_register), .sys_clk_source(src), .nmi_pulse(nmi), .clock_fail_flag(flag), .pb1_enable(pb1),
    .oscillator_output_pin(pin), .flash_clk_source(fsrc), .periph_reg_clk_en(rce));
  task automatic chk(input string n, input logic [1:0] e, input logic [1:0] s);
    checks++;
    if (s !== e)
    begin
      failures++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // restart first, so a stale stop cannot refire
  task automatic t_recover;
    run = 1;
    cyc(3);
    rc = 1;
    cyc(1);
    rc = 0;
    chk("restored", SRC_PRIMARY, src);
  endtask
  task automatic t_fail;
    int n;
    n = 0;
    run = 0;
    dis = 1;
    while (nmi !== 1'b1 && n < 30)
    begin
      cyc(1);
      n++;
    end
    chk("source", SRC_BACKUP, src);
    chk("latency", 1, n >= FAIL_TIMEOUT && n <= FAIL_TIMEOUT + 4);
    cyc(1);
    chk("nmi once", 0, nmi);
    cyc(20);
    chk("flag", 1, flag);
    chk("pb1", 1, pb1);
    // reconfigure with the clock still dead must refire at once
    rc = 1;
    cyc(1);
    rc = 0;
    chk("rcfg src", SRC_PRIMARY, src);
    chk("rcfg flag", 0, flag);
    cyc(1);
    chk("refire nmi", 1, nmi);
    chk("refire src", SRC_BACKUP, src);
    t_recover();
  endtask
  task automatic t_sleep;
    slp = 1;
    cyc(2);
    run = 0;
    cyc(30);
    chk("sleep", 0, flag);
    slp = 0;
    cyc(16);
    chk("wake", 1, flag);
    t_recover();
  endtask
  task automatic t_misc;
    logic p;
    {om, fp, special_function_register, tk} = 4'hf;
    cyc(3);
    p = pin;
    cyc(1);
    chk("pin", !p, pin);
    chk("flash", SRC_FAST_RC, fsrc);
    chk("reg clk", 1, rce);
    {om, fp, special_function_register} = 3'h0;
    cyc(2);
    chk("pin off", 0, pin);
    chk("flash rw", SRC_PRIMARY, fsrc);
    chk("reg clk off", 0, rce);
  endtask
  // reset in the middle of a failure clears everything but the bus clock
  task automatic t_reset;
    run = 0;
    {om, special_function_register} = 2'h3;
    cyc(FAIL_TIMEOUT + 4);
    chk("pre flag", 1, flag);
    srst = 1;
    cyc(2);
    chk("rst src", SRC_PRIMARY, src);
    chk("rst flag", 0, flag);
    chk("rst nmi", 0, nmi);
    chk("rst pb1", 1, pb1);
    chk("rst pin", 0, pin);
    chk("rst reg clk", 0, rce);
    run = 1;
    {om, special_function_register} = 2'h0;
    srst = 0;
    cyc(3);
    chk("after rst flag", 0, flag);
  endtask
  task automatic report_and_stop;
    if (failures == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    cyc(16);
    srst = 0;
    cyc(2);
    t_fail();
    t_sleep();
    t_misc();
    t_reset();
    report_and_stop();
  end
  initial
  begin
    repeat (3000) @(posedge mclk);
    failures++;
    report_and_stop();
  end
endmodule
`default_nettype wire
